// ### common/jtp_pkg.sv
// Package for the test access port: states, widths, instructions, carriers
`default_nettype none
package jtp_pkg;
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR, ST_EXIT2_DR,
    ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } jtp_state_e;
  localparam int IR_W = 4;
  localparam int BSR_W = 8;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
  localparam logic [IR_W-1:0] IR_RESET_VAL = 4'hF;
  localparam logic [IR_W-1:0] INS_EXTEST = 4'h0;
  localparam logic [IR_W-1:0] INS_SAMPLE = 4'h2;
  localparam logic [IR_W-1:0] INS_BYPASS = 4'hF;
  localparam int RESET_TMS_CYCLES = 5;
  // Probe-facing pins after synchronisation
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } jtp_pins_s;
endpackage
`default_nettype wire

// ### src/jtp_tap.sv
// Test access port controller with instruction, bypass and boundary registers
`default_nettype none
module jtp_tap
  import jtp_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             tck,
  input  wire logic             tms,
  input  wire logic             tdi,
  input  wire logic             trst_n,
  input  wire logic [BSR_W-1:0] bsr_capture,
  output logic                  tdo,
  output logic                  tdo_oe,
  output logic [BSR_W-1:0]      bsr_out,
  output logic [IR_W-1:0]       cur_ir,
  output logic                  test_active
);

  // Two-stage synchronisers; first stage read by the second only
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  logic       tck_d_ff;
  jtp_pins_s  pins;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_ff <= 4'h8; // Test reset stage starts released, as its pin idles
      sync2_ff <= 4'h8;
      tck_d_ff <= 1'b0;
    end
    else
    begin
      sync1_ff <= {trst_n, tdi, tms, tck};
      sync2_ff <= sync1_ff;
      tck_d_ff <= sync2_ff[0];
    end
  end

  assign pins = jtp_pins_s'({sync2_ff[0], sync2_ff[1], sync2_ff[2], sync2_ff[3]});

  // Edge detection on the sampled test clock
  wire tck_rise = pins.tck & ~tck_d_ff;
  wire tck_fall = ~pins.tck & tck_d_ff;
  // Test reset as seen by the controller; taken from the synchronised pin alone, not combined with chip reset
  wire trst_act = ~pins.trst_n;

  // Next-state table, mode select is the only steering input
  function automatic jtp_state_e next_state(input jtp_state_e s, input logic m);
    unique case (s)
      ST_RESET:    next_state = m ? ST_RESET    : ST_IDLE;
      ST_IDLE:     next_state = m ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_DR:   next_state = m ? ST_SEL_IR   : ST_CAP_DR;
      ST_CAP_DR:   next_state = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: next_state = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: next_state = m ? ST_UPD_DR   : ST_PAUSE_DR;
      ST_PAUSE_DR: next_state = m ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: next_state = m ? ST_UPD_DR   : ST_SHIFT_DR;
      ST_UPD_DR:   next_state = m ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_IR:   next_state = m ? ST_RESET    : ST_CAP_IR;
      ST_CAP_IR:   next_state = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: next_state = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: next_state = m ? ST_UPD_IR   : ST_PAUSE_IR;
      ST_PAUSE_IR: next_state = m ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: next_state = m ? ST_UPD_IR   : ST_SHIFT_IR;
      ST_UPD_IR:   next_state = m ? ST_SEL_DR   : ST_IDLE;
    endcase
  endfunction

  jtp_state_e state_ff;
  jtp_state_e nxt_state;
  assign nxt_state = next_state(state_ff, pins.tms);

  // Controller; the test reset acts at once, not on a test clock edge
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      state_ff <= ST_RESET;
    else if (trst_act)
      state_ff <= ST_RESET;
    else if (tck_rise)
      state_ff <= nxt_state;
  end

  // Register selection decoded from the current instruction
  logic [IR_W-1:0] ir_shift_ff;
  logic [IR_W-1:0] ir_ff;
  logic            byp_ff;
  logic [BSR_W-1:0] bsr_shift_ff;
  logic [BSR_W-1:0] bsr_upd_ff;

  wire sel_bsr = (ir_ff == INS_EXTEST) | (ir_ff == INS_SAMPLE);
  wire in_cap_dr   = (state_ff == ST_CAP_DR);
  wire in_shift_dr = (state_ff == ST_SHIFT_DR);
  wire in_upd_dr   = (state_ff == ST_UPD_DR);
  wire in_cap_ir   = (state_ff == ST_CAP_IR);
  wire in_shift_ir = (state_ff == ST_SHIFT_IR);
  wire in_upd_ir   = (state_ff == ST_UPD_IR);
  wire in_shift    = in_shift_dr | in_shift_ir;
  wire act_ok      = tck_rise & ~trst_act;

  // Instruction shift stage; pause and exit states hold it
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      ir_shift_ff <= IR_RESET_VAL;
    else if (act_ok && in_cap_ir)
      ir_shift_ff <= IR_CAPTURE;
    else if (act_ok && in_shift_ir)
      ir_shift_ff <= {pins.tdi, ir_shift_ff[IR_W-1:1]};
  end

  // Current instruction, updated on the falling edge in Update-IR
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      ir_ff <= IR_RESET_VAL;
    else if (trst_act || state_ff == ST_RESET)
      ir_ff <= IR_RESET_VAL;
    else if (tck_fall && in_upd_ir)
      ir_ff <= ir_shift_ff;
  end

  // Bypass stage and boundary shift chain
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      byp_ff <= 1'b0;
      bsr_shift_ff <= '0;
    end
    else if (act_ok)
    begin
      if (in_cap_dr)
        byp_ff <= 1'b0;
      else if (in_shift_dr && !sel_bsr)
        byp_ff <= pins.tdi;
      if (in_cap_dr && sel_bsr)
        bsr_shift_ff <= bsr_capture;
      else if (in_shift_dr && sel_bsr)
        bsr_shift_ff <= {pins.tdi, bsr_shift_ff[BSR_W-1:1]};
    end
  end

  // Boundary latch moves only in Update-DR, so shifting never disturbs it
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      bsr_upd_ff <= '0;
    else if (tck_fall && in_upd_dr && sel_bsr)
      bsr_upd_ff <= bsr_shift_ff;
  end

  // Output stage on the falling test clock; the probe samples mid-high
  logic tdo_ff;
  logic tdo_oe_ff;
  wire  dr_bit  = sel_bsr ? bsr_shift_ff[0] : byp_ff;
  wire  nxt_tdo = in_shift_ir ? ir_shift_ff[0] : dr_bit;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tdo_ff <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end
    else if (trst_act)
      tdo_oe_ff <= 1'b0;
    else if (tck_fall)
    begin
      tdo_ff <= nxt_tdo;
      tdo_oe_ff <= in_shift;
    end
  end

  assign tdo = tdo_ff;
  assign tdo_oe = tdo_oe_ff;
  assign bsr_out = bsr_upd_ff;
  assign cur_ir = ir_ff;
  // Test logic idle in reset state; normal function undisturbed
  assign test_active = (state_ff != ST_RESET);

  // Helper: count consecutive high mode-select rising edges
  logic [2:0] hi_cnt_ff;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      hi_cnt_ff <= 3'h0;
    else if (tck_rise)
      hi_cnt_ff <= !pins.tms ? 3'h0 : (hi_cnt_ff == 3'h7 ? 3'h7 : hi_cnt_ff + 3'h1);
  end

  AST_FIVE_HIGH_RESET: assert property (@(posedge clk) disable iff (!nrst)
    hi_cnt_ff >= 3'(RESET_TMS_CYCLES) |-> state_ff == ST_RESET)
    else $error("five high mode-select clocks did not reach reset");

  AST_RESET_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    state_ff == ST_RESET && tck_rise && pins.tms |=> state_ff == ST_RESET)
    else $error("reset state left with mode select high");

  AST_IDLE_HOLD: assert property (@(posedge clk) disable iff (!nrst || trst_act)
    state_ff == ST_IDLE && tck_rise && !pins.tms |=> state_ff == ST_IDLE)
    else $error("idle left with mode select low");

  AST_SEL_DR_LOW: assert property (@(posedge clk) disable iff (!nrst || trst_act)
    state_ff == ST_SEL_DR && tck_rise && !pins.tms |=> state_ff == ST_CAP_DR)
    else $error("select-dr did not start a data scan");

  AST_SEL_IR_LOW: assert property (@(posedge clk) disable iff (!nrst || trst_act)
    state_ff == ST_SEL_IR && tck_rise && !pins.tms |=> state_ff == ST_CAP_IR)
    else $error("select-ir did not start an instruction scan");

  AST_TRST: assert property (@(posedge clk) disable iff (!nrst)
    trst_act |=> state_ff == ST_RESET && !tdo_oe)
    else $error("test reset did not initialise controller");

  AST_IR_SHIFT: assert property (@(posedge clk) disable iff (!nrst || trst_act)
    in_shift_ir && tck_rise |=> ir_shift_ff == {$past(pins.tdi), $past(ir_shift_ff[IR_W-1:1])})
    else $error("instruction shift wrong");

  AST_IR_STABLE: assert property (@(posedge clk) disable iff (!nrst || trst_act)
    in_shift_ir |=> $stable(ir_ff))
    else $error("current instruction changed while shifting");

  AST_BSR_STABLE: assert property (@(posedge clk) disable iff (!nrst)
    in_shift_dr |=> $stable(bsr_upd_ff))
    else $error("boundary latch changed while shifting");

  AST_PAUSE_DR_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    state_ff == ST_PAUSE_DR |=> $stable(bsr_shift_ff) && $stable(byp_ff))
    else $error("data register moved in pause");

  AST_OE_SHIFT: assert property (@(posedge clk) disable iff (!nrst)
    tck_fall && !trst_act |=> tdo_oe == $past(in_shift))
    else $error("output enable not tied to shift states");

  // Transitions beyond the resting states
  AST_SEL_DR_HIGH: assert property (@(posedge clk) disable iff (!nrst || trst_act)
    state_ff == ST_SEL_DR && tck_rise && pins.tms |=> state_ff == ST_SEL_IR)
    else $error("select-dr did not move on with mode select high");

  AST_SEL_IR_HIGH: assert property (@(posedge clk) disable iff (!nrst || trst_act)
    state_ff == ST_SEL_IR && tck_rise && pins.tms |=> state_ff == ST_RESET)
    else $error("select-ir did not fall back to reset");

  AST_EXIT1_PASS: assert property (@(posedge clk) disable iff (!nrst || trst_act)
    (state_ff == ST_EXIT1_DR || state_ff == ST_EXIT1_IR) && tck_rise |=>
      state_ff != ST_EXIT1_DR && state_ff != ST_EXIT1_IR)
    else $error("exit1 state held for a second clock");

  AST_EXIT2_DR_BACK: assert property (@(posedge clk) disable iff (!nrst || trst_act)
    state_ff == ST_EXIT2_DR && tck_rise && !pins.tms |=> state_ff == ST_SHIFT_DR)
    else $error("exit2-dr did not return to data shift");

  AST_EXIT2_IR_BACK: assert property (@(posedge clk) disable iff (!nrst || trst_act)
    state_ff == ST_EXIT2_IR && tck_rise && !pins.tms |=> state_ff == ST_SHIFT_IR)
    else $error("exit2-ir did not return to instruction shift");

  AST_TCK_ONLY: assert property (@(posedge clk) disable iff (!nrst)
    !tck_rise && !trst_act |=> $stable(state_ff))
    else $error("controller moved without a test clock edge");

  // Capture, hold and update of the scan registers
  AST_IR_CAPTURE: assert property (@(posedge clk) disable iff (!nrst)
    in_cap_ir && act_ok |=> ir_shift_ff == IR_CAPTURE)
    else $error("instruction capture value not loaded");

  AST_PAUSE_IR_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    state_ff == ST_PAUSE_IR |=> $stable(ir_shift_ff))
    else $error("instruction shift moved in pause");

  AST_BSR_CAPTURE: assert property (@(posedge clk) disable iff (!nrst)
    in_cap_dr && sel_bsr && act_ok |=> bsr_shift_ff == $past(bsr_capture))
    else $error("boundary chain did not capture its inputs");

  AST_BYP_CAPTURE: assert property (@(posedge clk) disable iff (!nrst)
    in_cap_dr && act_ok |=> !byp_ff)
    else $error("bypass stage did not capture zero");

  AST_BSR_SHIFT: assert property (@(posedge clk) disable iff (!nrst)
    in_shift_dr && sel_bsr && act_ok |=> bsr_shift_ff == {$past(pins.tdi), $past(bsr_shift_ff[BSR_W-1:1])})
    else $error("boundary chain shift wrong");

  AST_BYP_SHIFT: assert property (@(posedge clk) disable iff (!nrst)
    in_shift_dr && !sel_bsr && act_ok |=> byp_ff == $past(pins.tdi))
    else $error("bypass stage did not take data in");

  AST_IR_UPDATE: assert property (@(posedge clk) disable iff (!nrst)
    in_upd_ir && tck_fall && !trst_act |=> cur_ir == $past(ir_shift_ff))
    else $error("instruction not latched in update");

  AST_BSR_UPDATE: assert property (@(posedge clk) disable iff (!nrst)
    in_upd_dr && sel_bsr && tck_fall |=> bsr_out == $past(bsr_shift_ff))
    else $error("boundary latch not loaded in update");

  AST_RESET_IR: assert property (@(posedge clk) disable iff (!nrst)
    state_ff == ST_RESET |=> cur_ir == IR_RESET_VAL)
    else $error("reset state did not restore the instruction");

  // Serial output moves only on the falling test clock
  AST_TDO_ON_FALL: assert property (@(posedge clk) disable iff (!nrst)
    !tck_fall |=> $stable(tdo))
    else $error("data out changed away from a falling test clock");

  AST_TDO_IR_BIT: assert property (@(posedge clk) disable iff (!nrst)
    tck_fall && !trst_act && in_shift_ir |=> tdo == $past(ir_shift_ff[0]))
    else $error("data out not the instruction shift bit");

  AST_TDO_BYP_BIT: assert property (@(posedge clk) disable iff (!nrst)
    tck_fall && !trst_act && in_shift_dr && !sel_bsr |=> tdo == $past(byp_ff))
    else $error("data out not the bypass stage");

  COV_DR_UPDATE: cover property (@(posedge clk) disable iff (!nrst) tck_fall && in_upd_dr && sel_bsr);
  COV_IR_UPDATE: cover property (@(posedge clk) disable iff (!nrst) tck_fall && in_upd_ir);
  COV_PAUSE_IR:  cover property (@(posedge clk) disable iff (!nrst) state_ff == ST_EXIT2_IR && tck_rise && !pins.tms);
  COV_TRST:      cover property (@(posedge clk) disable iff (!nrst) trst_act && state_ff == ST_SHIFT_DR);
  COV_PAUSE_DR:  cover property (@(posedge clk) disable iff (!nrst) state_ff == ST_EXIT2_DR && tck_rise && !pins.tms);

endmodule
`default_nettype wire

// ### tb/jtp_probe.sv
// Debug probe model driving the test access port pins
`default_nettype none
module jtp_probe
(
  input  wire logic clk,
  input  wire logic tdo,
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      trst_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // Test clock parked low between frames; data in parked as a serial-wire probe leaves it
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b1;
  end

  // One 8-clk test clock; pins move at the fall, tdo taken mid-high
  task automatic step(input logic m, input logic d, output logic o);
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge clk);
    tck <= 1'b1;
    repeat (2) @(posedge clk);
    o = tdo;
    repeat (2) @(posedge clk);
    tck <= 1'b0;
  endtask

  // Test reset pulse long enough for the synchroniser
  task automatic pulse_trst;
    trst_n <= 1'b0;
    repeat (4) @(posedge clk);
    trst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ### tb/jtp_tap_bench.sv
// Self-checking bench for the test access port controller
`default_nettype none
module jtp_tap_bench import jtp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clk;
  logic             nrst;
  logic             tck;
  logic             tms;
  logic             tdi;
  logic             trst_n;
  logic [BSR_W-1:0] bsr_capture;
  logic             tdo;
  logic             tdo_oe;
  logic [BSR_W-1:0] bsr_out;
  logic [IR_W-1:0]  cur_ir;
  logic             test_active;
  logic [7:0]       dout;
  logic             o;
  int               num_errors;
  int               check_count;

  jtp_tap dut_u (.clk, .nrst, .tck, .tms, .tdi, .trst_n, .bsr_capture, .tdo, .tdo_oe, .bsr_out, .cur_ir,
    .test_active);
  jtp_probe probe_u (.clk, .tdo, .tck, .tms, .tdi, .trst_n);

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask

  task automatic end_of_test;
    if (num_errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Scan from Idle with a pause after bit 1; held latch must not move meanwhile
  task automatic scan(input logic ir, input int n, input logic [7:0] din, input logic [7:0] held);
    dout = 8'h00;
    probe_u.step(1'b1, 1'b0, o);
    if (ir)
      probe_u.step(1'b1, 1'b0, o);
    probe_u.step(1'b0, 1'b0, o);
    probe_u.step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++)
    begin
      probe_u.step(i == n - 1 || i == 1, din[i], o);
      dout[i] = o;
      if (i == 0)
        check("tdo_oe shift", 8'h01, {7'h00, tdo_oe});
      if (i == 1)
      begin
        probe_u.step(1'b0, 1'b1, o);
        probe_u.step(1'b0, 1'b1, o);
        check("tdo_oe pause", 8'h00, {7'h00, tdo_oe});
        check("latch", held, ir ? {4'h0, cur_ir} : bsr_out);
        probe_u.step(1'b1, 1'b0, o);
        probe_u.step(1'b0, 1'b0, o);
      end
    end
    probe_u.step(1'b1, 1'b0, o);
    probe_u.step(1'b0, 1'b0, o);
    repeat (3) @(posedge clk);
  endtask

  // Reset state holds under high mode select, idle under low
  task automatic t_reset;
    check("active rst", 8'h00, {7'h00, test_active});
    check("ir rst", {4'h0, IR_RESET_VAL}, {4'h0, cur_ir});
    repeat (3) probe_u.step(1'b1, 1'b0, o);
    repeat (3) @(posedge clk);
    check("active hold", 8'h00, {7'h00, test_active});
    repeat (3) probe_u.step(1'b0, 1'b0, o);
    repeat (3) @(posedge clk);
    check("active idle", 8'h01, {7'h00, test_active});
    check("tdo_oe idle", 8'h00, {7'h00, tdo_oe});
  endtask

  // Instruction load, boundary scan and bypass scan back to back
  task automatic t_scans;
    scan(1'b1, IR_W, {4'h0, INS_SAMPLE}, {4'h0, IR_RESET_VAL});
    check("ir capture", {4'h0, IR_CAPTURE}, dout);
    check("ir sample", {4'h0, INS_SAMPLE}, {4'h0, cur_ir});
    scan(1'b0, BSR_W, 8'h3C, 8'h00);
    check("bsr capture", 8'hA5, dout);
    check("bsr update", 8'h3C, bsr_out);
    scan(1'b1, IR_W, {4'h0, INS_BYPASS}, {4'h0, INS_SAMPLE});
    scan(1'b0, BSR_W, 8'hC9, 8'h3C);
    check("bypass", 8'h92, dout);
    check("bsr kept", 8'h3C, bsr_out);
  endtask

  // Test reset pin, then five high mode-select clocks from Shift-DR
  task automatic t_resets;
    scan(1'b1, IR_W, {4'h0, INS_EXTEST}, {4'h0, INS_BYPASS});
    check("ir extest", {4'h0, INS_EXTEST}, {4'h0, cur_ir});
    probe_u.pulse_trst;
    check("trst active", 8'h00, {7'h00, test_active});
    check("trst ir", {4'h0, IR_RESET_VAL}, {4'h0, cur_ir});
    probe_u.step(1'b0, 1'b0, o);
    scan(1'b1, IR_W, {4'h0, INS_EXTEST}, {4'h0, IR_RESET_VAL});
    probe_u.step(1'b1, 1'b0, o);
    repeat (2) probe_u.step(1'b0, 1'b0, o);
    repeat (4) probe_u.step(1'b1, 1'b0, o);
    repeat (3) @(posedge clk);
    check("four high", 8'h01, {7'h00, test_active});
    probe_u.step(1'b1, 1'b0, o);
    repeat (3) @(posedge clk);
    check("five high", 8'h00, {7'h00, test_active});
    check("five ir", {4'h0, IR_RESET_VAL}, {4'h0, cur_ir});
  endtask

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Watchdog well beyond the fewer than a thousand clocks the tests need
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_of_test;
  end

  initial
  begin
    nrst = 1'b0;
    bsr_capture = 8'hA5;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset;
    t_scans;
    t_resets;
    end_of_test;
  end
endmodule
`default_nettype wire
